// >>> include/sbst_params.svh
// timing counts, widths, instruction codes and reset values for the scan test port
`ifndef SBST_PARAMS_SVH
`define SBST_PARAMS_SVH
`define SBST_IR_WIDTH 3
`define SBST_ID_WIDTH 32
`define SBST_BSR_LEN 109
`define SBST_OE_CELL 108
`define SBST_RST_CNT 5
`define SBST_IR_CAPTURE 3'h1
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPLEZ 3'h2
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_BYPASS 3'h7
// identification code: an arbitrary value that names no maker or part
`define SBST_ID_VALUE 32'h0a5a5a5b
`endif

// >>> include/sbst_pkg.sv
// types shared by the scan test port
package sbst_pkg;
  // sixteen-state test controller
  typedef enum logic [3:0] {
    ResetSt, IdleSt, SelDrSt, CapDrSt, ShDrSt, Ex1DrSt, PauseDrSt, Ex2DrSt, UpdDrSt,
    SelIrSt, CapIrSt, ShIrSt, Ex1IrSt, PauseIrSt, Ex2IrSt, UpdIrSt
  } sbst_state_e;
  // synchronised test pins
  typedef struct packed {
    logic testClk;
    logic modeSel;
    logic dataIn;
  } sbst_pins_s;
endpackage

// >>> src/sbst_tap.sv
// scan test port controller with instruction, bypass, id and boundary registers
// Overview of operation
// - sample inputs on rise, outputs on fall
// - mode select steers controller, reads high floating
// - serial input enters selected register msb
// - serial output from lsb, changes on fall
// - output driver enabled only while shifting
// - instruction selects exactly one scan register
// - five high mode selects reset logic
// - test reset never disturbs memory operation
// - power-up reset floats serial output
// - three bit serially loaded instruction register
// - instruction presets to identification on reset
// - instruction capture loads pattern 01
// - bypass is one register bit
// - bypass bit cleared when bypass executes
// - boundary register captures ring, then shifts
// - extest, sample and samplez capture ring
// - boundary cell per ball, msb near input
// - identification register captures 32-bit code
// - samplez floats memory output bus
// - cell 108 enables output bus, preset high
`timescale 1ns/1ns
`include "sbst_params.svh"
module sbst_tap #(
  parameter int BSR_LEN = `SBST_BSR_LEN, // boundary cells including spare balls
  parameter logic [`SBST_ID_WIDTH-1:0] ID_CODE = `SBST_ID_VALUE // arbitrary value
) (
  input wire logic core_clk, // 125 mhz system clock
  input wire logic rst_n, // asynchronous active low reset
  input wire logic testClk, // test clock pin, sampled
  input wire logic modeSel, // mode select pin, pulled up outside
  input wire logic dataIn, // serial data in pin, pulled up outside
  output logic dataOut, // serial data out
  output logic dataOutEn, // serial data out enable, high drives
  input wire logic [BSR_LEN-1:0] ringIn, // live values of the ball ring
  output logic [BSR_LEN-1:0] ringOut, // latched boundary update values
  output logic extestMode, // boundary drives the balls
  output logic memOutFloat // memory output bus held high impedance
);
  // module state except the reset synchroniser in one packed struct
  typedef struct packed {
    // three-stage synchroniser on the test pins
    sbst_pkg::sbst_pins_s s1;
    sbst_pkg::sbst_pins_s s2;
    sbst_pkg::sbst_pins_s s3;
    logic clkLvl;
    // controller state and the instruction stages
    sbst_pkg::sbst_state_e st;
    logic [`SBST_IR_WIDTH-1:0] irSh;
    logic [`SBST_IR_WIDTH-1:0] ir;
    // bypass and identification stages
    logic byp;
    logic [`SBST_ID_WIDTH-1:0] idSh;
    // boundary shift stage and update latch
    logic [BSR_LEN-1:0] bsrSh;
    logic [BSR_LEN-1:0] bsrUpd;
    // run of rises seen with mode select high
    logic [2:0] highCnt;
    // serial output flops, changed on falls only
    logic tdo;
    logic tdoEn;
  } sbst_reg_s;

  // registered state and its next value
  sbst_reg_s r; // registered state
  sbst_reg_s next_r; // next state
  // reset synchroniser, kept apart because it clears on the raw pin
  logic [1:0] rstSync;
  logic rstLocal_n; // synchronised reset
  // decoded strobes of the sampled test clock
  logic clkRise; // agreed rising edge of the test clock
  logic clkFall; // agreed falling edge
  // sampled test inputs
  logic tms; // agreed mode select
  logic tdi; // agreed data in
  // serial path helpers
  logic serBit; // lsb of the selected register
  logic shiftDr; // in data shift state
  logic shiftIr; // in instruction shift state

  // reset copy released two core clocks after the pin
  assign rstLocal_n = rstSync[1];
  // a change counts once second and third stage agree
  assign clkRise = (r.s2.testClk == r.s3.testClk) && r.s3.testClk && !r.clkLvl;
  assign clkFall = (r.s2.testClk == r.s3.testClk) && !r.s3.testClk && r.clkLvl;
  assign tms = r.s3.modeSel;
  assign tdi = r.s3.dataIn;
  // state decodes for the output enable
  assign shiftDr = (r.st == sbst_pkg::ShDrSt);
  assign shiftIr = (r.st == sbst_pkg::ShIrSt);

  // pick the lsb of the one register in the path
  always_comb
  begin
    // instruction shift puts the instruction register in the path
    if (r.st == sbst_pkg::ShIrSt)
    begin
      serBit = r.irSh[0];
    end
    else
    begin
      // otherwise the instruction picks the data register
      unique case (r.ir)
        `SBST_INS_EXTEST, `SBST_INS_SAMPLE, `SBST_INS_SAMPLEZ: serBit = r.bsrSh[0];
        `SBST_INS_IDCODE: serBit = r.idSh[0];
        default: serBit = r.byp; // reserved and bypass use the single bit
      endcase
    end
  end

  // next state of the whole port
  always_comb
  begin
    next_r = r;
    // pins enter the first stage, stages shift along
    next_r.s1 = '{testClk: testClk, modeSel: modeSel, dataIn: dataIn};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // track the agreed test clock level for edge detection
    if (r.s2.testClk == r.s3.testClk)
    begin
      next_r.clkLvl = r.s3.testClk;
    end
    // everything in this branch moves on a rising test clock only; the output update after it moves on a fall
    if (clkRise)
    begin
      // five rising edges with mode select high force reset
      if (!tms)
      begin
        next_r.highCnt = 3'h0;
      end
      else if (r.highCnt != 3'(`SBST_RST_CNT))
      begin
        // count up, saturating at the reset count
        next_r.highCnt = r.highCnt + 3'h1;
      end
      // standard controller transitions
      unique case (r.st)
        // reset and idle
        sbst_pkg::ResetSt: next_r.st = tms ? sbst_pkg::ResetSt : sbst_pkg::IdleSt;
        sbst_pkg::IdleSt: next_r.st = tms ? sbst_pkg::SelDrSt : sbst_pkg::IdleSt;
        // data register column
        sbst_pkg::SelDrSt: next_r.st = tms ? sbst_pkg::SelIrSt : sbst_pkg::CapDrSt;
        sbst_pkg::CapDrSt: next_r.st = tms ? sbst_pkg::Ex1DrSt : sbst_pkg::ShDrSt;
        sbst_pkg::ShDrSt: next_r.st = tms ? sbst_pkg::Ex1DrSt : sbst_pkg::ShDrSt;
        sbst_pkg::Ex1DrSt: next_r.st = tms ? sbst_pkg::UpdDrSt : sbst_pkg::PauseDrSt;
        sbst_pkg::PauseDrSt: next_r.st = tms ? sbst_pkg::Ex2DrSt : sbst_pkg::PauseDrSt;
        sbst_pkg::Ex2DrSt: next_r.st = tms ? sbst_pkg::UpdDrSt : sbst_pkg::ShDrSt;
        sbst_pkg::UpdDrSt: next_r.st = tms ? sbst_pkg::SelDrSt : sbst_pkg::IdleSt;
        // instruction register column
        sbst_pkg::SelIrSt: next_r.st = tms ? sbst_pkg::ResetSt : sbst_pkg::CapIrSt;
        sbst_pkg::CapIrSt: next_r.st = tms ? sbst_pkg::Ex1IrSt : sbst_pkg::ShIrSt;
        sbst_pkg::ShIrSt: next_r.st = tms ? sbst_pkg::Ex1IrSt : sbst_pkg::ShIrSt;
        sbst_pkg::Ex1IrSt: next_r.st = tms ? sbst_pkg::UpdIrSt : sbst_pkg::PauseIrSt;
        sbst_pkg::PauseIrSt: next_r.st = tms ? sbst_pkg::Ex2IrSt : sbst_pkg::PauseIrSt;
        sbst_pkg::Ex2IrSt: next_r.st = tms ? sbst_pkg::UpdIrSt : sbst_pkg::ShIrSt;
        sbst_pkg::UpdIrSt: next_r.st = tms ? sbst_pkg::SelDrSt : sbst_pkg::IdleSt;
      endcase
      // mode select high pushes back to reset after five rises
      if (tms && r.highCnt >= 3'(`SBST_RST_CNT - 1))
      begin
        next_r.st = sbst_pkg::ResetSt;
      end
      // register actions of the current state
      unique case (r.st)
        // capture the fixed pattern for path checks
        sbst_pkg::CapIrSt:
        begin
          next_r.irSh = {1'b0, 2'(`SBST_IR_CAPTURE)};
        end
        // shift the instruction towards the output
        sbst_pkg::ShIrSt:
        begin
          next_r.irSh = {tdi, r.irSh[`SBST_IR_WIDTH-1:1]};
        end
        // the new instruction takes effect
        sbst_pkg::UpdIrSt:
        begin
          next_r.ir = r.irSh;
          // the bypass instruction clears its bit at once
          if (r.irSh == `SBST_INS_BYPASS)
          begin
            next_r.byp = 1'b0;
          end
        end
        // capture into the selected data register
        sbst_pkg::CapDrSt:
        begin
          unique case (r.ir)
            // ring snapshot for the three boundary instructions
            `SBST_INS_EXTEST, `SBST_INS_SAMPLE, `SBST_INS_SAMPLEZ: next_r.bsrSh = ringIn;
            `SBST_INS_IDCODE: next_r.idSh = ID_CODE;
            default: next_r.byp = 1'b0;
          endcase
        end
        // shift the selected data register
        sbst_pkg::ShDrSt:
        begin
          unique case (r.ir)
            // boundary register takes the serial input at its msb
            `SBST_INS_EXTEST, `SBST_INS_SAMPLE, `SBST_INS_SAMPLEZ:
              next_r.bsrSh = {tdi, r.bsrSh[BSR_LEN-1:1]};
            `SBST_INS_IDCODE: next_r.idSh = {tdi, r.idSh[`SBST_ID_WIDTH-1:1]};
            default: next_r.byp = tdi;
          endcase
        end
        // latch boundary values onto the ring outputs
        sbst_pkg::UpdDrSt:
        begin
          if (r.ir == `SBST_INS_EXTEST || r.ir == `SBST_INS_SAMPLE)
          begin
            next_r.bsrUpd = r.bsrSh;
          end
        end
        // other states leave the shift registers alone
        default:
        begin
          next_r.irSh = r.irSh;
        end
      endcase
      // entering or holding the reset state presets instruction and the output enable cell
      if (next_r.st == sbst_pkg::ResetSt)
      begin
        next_r.ir = `SBST_INS_IDCODE;
        next_r.bsrUpd[`SBST_OE_CELL] = 1'b1;
      end
    end
    // output updates only on the falling edge
    if (clkFall)
    begin
      // the new lsb reaches the pin; the enable follows the shift states
      next_r.tdo = serBit;
      next_r.tdoEn = shiftDr || shiftIr;
    end
  end

  // synchroniser on the raw reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      // a one walks through both stages after release
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // register the rest of the state on the synchronised reset
  always_ff @(posedge core_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      // power-up reset floats the output and presets identification
      // synchroniser stages preset to the idle pin levels
      r.s1 <= '{testClk: 1'b0, modeSel: 1'b1, dataIn: 1'b1};
      r.s2 <= '{testClk: 1'b0, modeSel: 1'b1, dataIn: 1'b1};
      r.s3 <= '{testClk: 1'b0, modeSel: 1'b1, dataIn: 1'b1};
      r.clkLvl <= 1'b0;
      r.st <= sbst_pkg::ResetSt;
      r.irSh <= `SBST_INS_IDCODE;
      r.ir <= `SBST_INS_IDCODE;
      r.byp <= 1'b0;
      r.idSh <= '0;
      r.bsrSh <= '0;
      r.bsrUpd <= BSR_LEN'(1) << `SBST_OE_CELL;
      r.highCnt <= 3'h0;
      r.tdo <= 1'b0;
      r.tdoEn <= 1'b0;
    end
    else
    begin
      // registered state follows the next value
      r.s1 <= next_r.s1;
      r.s2 <= next_r.s2;
      r.s3 <= next_r.s3;
      r.clkLvl <= next_r.clkLvl;
      r.st <= next_r.st;
      r.irSh <= next_r.irSh;
      r.ir <= next_r.ir;
      r.byp <= next_r.byp;
      r.idSh <= next_r.idSh;
      r.bsrSh <= next_r.bsrSh;
      r.bsrUpd <= next_r.bsrUpd;
      r.highCnt <= next_r.highCnt;
      r.tdo <= next_r.tdo;
      r.tdoEn <= next_r.tdoEn;
    end
  end

  // test logic only gates ball values under extest and samplez; memory timing is untouched
  // serial pin outputs come straight from flops
  assign dataOut = r.tdo;
  assign dataOutEn = r.tdoEn;
  assign ringOut = r.bsrUpd;
  // instruction decodes for the memory side
  assign extestMode = (r.ir == `SBST_INS_EXTEST);
  assign memOutFloat = (r.ir == `SBST_INS_SAMPLEZ) || (extestMode && !r.bsrUpd[`SBST_OE_CELL]);
endmodule

// >>> verification/sbst_tap_sva.sv
// pin-level assertions for the scan test port
`timescale 1ns/1ns
module sbst_tap_sva #(
  parameter int BSR_LEN = 109
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic testClk,
  input wire logic modeSel,
  input wire logic dataIn,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic [BSR_LEN-1:0] ringIn,
  input wire logic [BSR_LEN-1:0] ringOut,
  input wire logic extestMode,
  input wire logic memOutFloat
);
  logic lastClk; // raw test clock one cycle ago
  logic [2:0] hiCnt; // rises seen in a row with mode select high
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // count raw rises with mode select high, saturating at seven
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastClk <= 1'b0;
      hiCnt <= 3'h0;
    end
    else
    begin
      lastClk <= testClk;
      if (testClk && !lastClk)
      begin
        hiCnt <= !modeSel ? 3'h0 : (hiCnt == 3'h7 ? hiCnt : hiCnt + 3'h1);
      end
    end
  end
  out_on_fall_a: assert property ($changed(dataOut) |-> !$past(testClk, 2))
    else $error("serial out moved outside a low phase");
  en_on_fall_a: assert property ($changed(dataOutEn) |-> !$past(testClk, 2))
    else $error("serial out enable moved outside a low phase");
  out_stands_a: assert property ($changed(dataOut) |=> $stable(dataOut) [*6])
    else $error("serial out did not stand for a period");
  en_holds_a: assert property ($rose(dataOutEn) |-> dataOutEn [*8])
    else $error("serial out enable dropped within a period");
  update_on_rise_a: assert property ($changed(ringOut) |-> $past(testClk, 2))
    else $error("boundary latch changed outside a high phase");
  mode_on_rise_a: assert property ($changed({extestMode, memOutFloat}) |-> $past(testClk, 2))
    else $error("instruction outputs changed outside a high phase");
  float_cell_a: assert property (extestMode |-> memOutFloat == !ringOut[108])
    else $error("output bus float does not follow cell 108");
  tms_reset_a: assert property (hiCnt == 3'h5 && $past(hiCnt) == 3'h4 |->
    ##[1:8] (!extestMode && !memOutFloat && !dataOutEn && ringOut[108]))
    else $error("five mode select highs did not reset the port");
  quiet_after_rst_a: assert property ($rose(rst_n) |-> !dataOutEn [*8])
    else $error("serial out driven after power-up reset");
endmodule
bind sbst_tap sbst_tap_sva #(.BSR_LEN(BSR_LEN)) chk_u (.core_clk(core_clk), .rst_n(rst_n), .testClk(testClk),
  .modeSel(modeSel), .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .ringIn(ringIn),
  .ringOut(ringOut), .extestMode(extestMode), .memOutFloat(memOutFloat));

// >>> verification/sbst_jtag_model.sv
// behavioural board-side scan controller on the test pins
`timescale 1ns/1ns
module sbst_jtag_model (
  output logic testClk,
  output logic modeSel,
  output logic dataIn,
  input wire logic dataOut,
  input wire logic dataOutEn
);
  // pins idle: clock low, pulled-up lines high
  initial
  begin
    testClk = 1'b0;
    modeSel = 1'b1;
    dataIn = 1'b1;
  end
  // one 80 ns period: pins set in low phase, serial out read just before the rise
  task automatic tck(input logic tms, input logic tdi, output logic tdo);
    modeSel = tms;
    dataIn = tdi;
    #40;
    tdo = dataOutEn ? dataOut : 1'bz; // an undriven pin never reads as data
    testClk = 1'b1;
    #40;
    testClk = 1'b0;
  endtask
  // idle to shift state, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    tck(1'b0, 1'b1, b);
    tck(1'b1, 1'b1, b);
    if (ir)
    begin
      tck(1'b1, 1'b1, b);
    end
    tck(1'b0, 1'b1, b);
    tck(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++)
    begin
      tck(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tck(1'b1, 1'b1, b);
    tck(1'b0, 1'b1, b);
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the scan test port
`timescale 1ns/1ns
`include "sbst_params.svh"
module tb_top;
  localparam int BSR = `SBST_BSR_LEN;
  logic core_clk, rst_n, testClk, modeSel, dataIn, dataOut, dataOutEn, extestMode, memOutFloat;
  logic [BSR-1:0] ringIn, ringOut, last; // ring values and expected latch
  logic [127:0] expQ[$]; // expected scan results, oldest first
  logic [127:0] got; // latest scan result
  logic [31:0] seed = 32'h8d84da8d;
  logic [2:0] codes[5] = '{`SBST_INS_BYPASS, 3'h3, `SBST_INS_SAMPLE, `SBST_INS_EXTEST, `SBST_INS_SAMPLEZ};
  int fail_count = 0;
  int compares = 0;
  event gotEv;
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  sbst_tap dut_u (.core_clk(core_clk), .rst_n(rst_n), .testClk(testClk), .modeSel(modeSel), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .ringIn(ringIn), .ringOut(ringOut), .extestMode(extestMode),
    .memOutFloat(memOutFloat));
  sbst_jtag_model host_u (.testClk(testClk), .modeSel(modeSel), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEn(dataOutEn));
  // xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_scan(input logic [127:0] act, input logic [127:0] exp);
    compares++;
    if (act !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: scan %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp_bit(input logic act, input logic exp);
    compares++;
    if (act !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: level %b expected %b", $time, act, exp);
    end
  endtask
  // note the expectation, run one scan, hand the result to the watcher
  task automatic run(input logic ir, input int n, input logic [127:0] din, input logic [127:0] exp);
    logic [127:0] dout;
    expQ.push_back(exp);
    host_u.scan(ir, n, din, dout);
    got = dout;
    -> gotEv;
  endtask
  // watcher: oldest note against each scan result
  initial
  begin
    forever
    begin
      @(gotEv);
      cmp_scan(got, expQ.pop_front());
    end
  end
  // main sequence
  initial
  begin
    logic [127:0] pat;
    logic b;
    rst_n = 1'b0;
    ringIn = '0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    cmp_bit(dataOutEn, 1'b0);
    run(1'b0, 32, '1, 128'(`SBST_ID_VALUE));
    for (int k = 0; k < 5; k++)
    begin
      pat = {xs(), xs(), xs(), xs()};
      ringIn = pat[BSR-1:0];
      run(1'b1, 3, 128'(codes[k]), 128'(`SBST_IR_CAPTURE));
      pat = {xs(), xs(), xs(), xs()};
      pat[`SBST_OE_CELL] = (k != 3);
      if (k < 2)
      begin
        run(1'b0, 16, pat, 128'({pat[14:0], 1'b0}));
      end
      else
      begin
        run(1'b0, BSR, pat, 128'(ringIn));
        last = (k < 4) ? pat[BSR-1:0] : last;
        cmp_bit(ringOut === last, 1'b1);
        cmp_bit(extestMode, k == 3);
        cmp_bit(memOutFloat, k != 2);
      end
    end
    // enter shift, then five mode select highs from mid-shift
    for (int i = 0; i < 9; i++)
    begin
      host_u.tck(1'(9'h1f2 >> i), 1'b1, b);
    end
    cmp_bit(memOutFloat, 1'b0);
    cmp_bit(ringOut[`SBST_OE_CELL], 1'b1);
    run(1'b0, 32, '0, 128'(`SBST_ID_VALUE));
    #1;
    report_and_stop();
  end
  // watchdog well past the expected run
  initial
  begin
    #300000;
    fail_count++;
    report_and_stop();
  end
endmodule
